/* pkg/cri_defines.vh */
// constants for the control, reset and start-up block
`ifndef CRI_DEFINES_VH
`define CRI_DEFINES_VH
`define CRI_I2C_ADDR 7'h18
`define CRI_PAGE_SEL_REG 8'h00
`define CRI_SW_RESET_REG 8'h01
`define CRI_SW_RESET_BIT 0
`define CRI_PWR_CTRL_REG 8'h02
`define CRI_STATUS_REG 8'h03
`define CRI_HP_STAGE_REG 8'h1F
`define CRI_SPK_STAGE_REG 8'h20
`define CRI_HPL_BIT 7
`define CRI_HPR_BIT 6
`define CRI_SPK_BIT 7
`define CRI_PLL_BIT 0
`define CRI_REG_RESET 8'h00
`define CRI_CLK_NS 5
`define CRI_RST_MIN_NS 10
`define CRI_RST_MIN_CYC ((`CRI_RST_MIN_NS + `CRI_CLK_NS - 1) / `CRI_CLK_NS)
`define CRI_INIT_NS 1000000
`define CRI_INIT_CYC (`CRI_INIT_NS / `CRI_CLK_NS)
`define CRI_PLL_NS 10000000
`define CRI_PLL_CYC (`CRI_PLL_NS / `CRI_CLK_NS)
`endif

/* design/cri_control_reset_init.v */
// i2c target with paged registers, reset and start-up sequencing
`timescale 1ns/1ps
`include "cri_defines.vh"
module cri_control_reset_init #(
  parameter INIT_CYCLES = `CRI_INIT_CYC,
  parameter PLL_CYCLES = `CRI_PLL_CYC
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  input wire reset_n_pin,
  // i2c pins, open drain
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  // overcurrent latch events
  input wire left_headphone_driver_ocp,
  input wire right_headphone_driver_ocp,
  input wire speaker_ocp,
  // block state
  output reg [7:0] block_power,
  output reg init_busy,
  output reg pll_clocks_ready,
  output reg left_headphone_driver_en,
  output reg right_headphone_driver_en,
  output reg speaker_positive_output_en,
  output reg speaker_negative_output_en
);
  localparam S_IDLE = 5'b00001;
  localparam S_ADDR = 5'b00010;
  localparam S_ACK = 5'b00100;
  localparam S_DATA = 5'b01000;
  localparam S_TX = 5'b10000;
  reg [4:0] state;
  reg scl_q, sda_q;
  reg [7:0] shreg;
  reg [3:0] bitcnt;
  reg rd_mode, have_ptr, ack_is_data;
  reg [7:0] ptr;
  reg page;
  reg [7:0] pwr_ctrl, hp_stage, spk_stage;
  reg [31:0] init_cnt, pll_cnt;
  reg [7:0] rst_cnt;
  reg soft_rst;
  reg [7:0] rd_data;
  reg do_write;
  reg [7:0] wr_data;
  wire any_rst = rst | soft_rst | (rst_cnt >= `CRI_RST_MIN_CYC);
  wire scl_rise = ~scl_q & scl_in;
  wire scl_fall = scl_q & ~scl_in;
  wire start_c = scl_in & scl_q & sda_q & ~sda_in;
  wire stop_c = scl_in & scl_q & ~sda_q & sda_in;
  always @* begin
    rd_data = 8'h00;
    if (ptr == `CRI_PAGE_SEL_REG) begin
      rd_data = {7'h00, page};
    end else if (!page && ptr == `CRI_PWR_CTRL_REG) begin
      rd_data = pwr_ctrl;
    end else if (!page && ptr == `CRI_STATUS_REG) begin
      rd_data = {6'h00, pll_clocks_ready, init_busy};
    end else if (page && ptr == `CRI_HP_STAGE_REG) begin
      rd_data = hp_stage;
    end else if (page && ptr == `CRI_SPK_STAGE_REG) begin
      rd_data = spk_stage;
    end
  end
  // reset pin pulse width counter, saturating
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rst_cnt <= 8'h00;
    end else if (!reset_n_pin) begin
      if (rst_cnt != 8'hFF) rst_cnt <= rst_cnt + 8'h01;
    end else begin
      rst_cnt <= 8'h00;
    end
  end
  // bus engine and registers; all state held at defaults during reset
  always @(posedge sys_clk or posedge any_rst) begin
    if (any_rst) begin
      state <= S_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      rd_mode <= 1'b0;
      have_ptr <= 1'b0;
      ack_is_data <= 1'b0;
      ptr <= 8'h00;
      page <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      do_write <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      do_write <= 1'b0;
      if (start_c) begin
        state <= S_ADDR;
        bitcnt <= 4'h0;
        have_ptr <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop_c) begin
        state <= S_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          S_ADDR, S_DATA: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_in};
              bitcnt <= bitcnt + 4'h1;
            end
            if (scl_fall && bitcnt == 4'h8) begin
              bitcnt <= 4'h0;
              if (state == S_ADDR) begin
                if (shreg[7:1] == `CRI_I2C_ADDR) begin
                  rd_mode <= shreg[0];
                  ack_is_data <= 1'b0;
                  sda_oe <= 1'b1;
                  state <= S_ACK;
                end else begin
                  state <= S_IDLE;
                end
              end else begin
                ack_is_data <= 1'b1;
                sda_oe <= 1'b1;
                state <= S_ACK;
                if (!have_ptr) begin
                  ptr <= shreg;
                  have_ptr <= 1'b1;
                end else begin
                  wr_data <= shreg;
                  do_write <= 1'b1;
                  ptr <= ptr + 8'h01;
                  if (ptr == `CRI_PAGE_SEL_REG) page <= shreg[0];
                end
              end
            end
          end
          S_ACK: begin
            // scl never driven; only sda pulled low
            if (scl_fall) begin
              if (rd_mode) begin
                shreg <= rd_data;
                sda_oe <= ~rd_data[7];
                bitcnt <= 4'h1;
                ptr <= ptr + 8'h01;
                state <= S_TX;
              end else begin
                sda_oe <= 1'b0;
                state <= S_DATA;
              end
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (bitcnt == 4'h8) begin
                sda_oe <= 1'b0;
                bitcnt <= 4'h9;
              end else if (bitcnt == 4'h9) begin
                if (sda_q) begin
                  state <= S_IDLE;
                  sda_oe <= 1'b0;
                end else begin
                  shreg <= rd_data;
                  sda_oe <= ~rd_data[7];
                  bitcnt <= 4'h1;
                  ptr <= ptr + 8'h01;
                end
              end else begin
                sda_oe <= ~shreg[7 - bitcnt[2:0]];
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end
  // register writes use the pointer before its increment
  wire [7:0] wptr = ptr - 8'h01;
  // soft reset is a registered one-cycle pulse; clearing it through its own
  // reset would leave only a glitch on the reset net
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= do_write & ~page & (wptr == `CRI_SW_RESET_REG) &
        wr_data[`CRI_SW_RESET_BIT];
    end
  end
  always @(posedge sys_clk or posedge any_rst) begin
    if (any_rst) begin
      pwr_ctrl <= `CRI_REG_RESET;
      hp_stage <= `CRI_REG_RESET;
      spk_stage <= `CRI_REG_RESET;
      init_busy <= 1'b1;
      init_cnt <= 32'h0;
      pll_cnt <= 32'h0;
      pll_clocks_ready <= 1'b0;
      block_power <= 8'h00;
      left_headphone_driver_en <= 1'b1;
      right_headphone_driver_en <= 1'b1;
      speaker_positive_output_en <= 1'b1;
      speaker_negative_output_en <= 1'b1;
    end else begin
      if (init_busy) begin
        init_cnt <= init_cnt + 32'h1;
        if (init_cnt >= INIT_CYCLES - 1) init_busy <= 1'b0;
      end
      block_power <= pwr_ctrl;
      if (pwr_ctrl[`CRI_PLL_BIT]) begin
        if (pll_cnt >= PLL_CYCLES - 1) begin
          pll_clocks_ready <= 1'b1;
        end else begin
          pll_cnt <= pll_cnt + 32'h1;
        end
      end else begin
        pll_cnt <= 32'h0;
        pll_clocks_ready <= 1'b0;
      end
      // overcurrent latch-off; set of a re-enable request below wins
      if (left_headphone_driver_ocp) left_headphone_driver_en <= 1'b0;
      if (right_headphone_driver_ocp) right_headphone_driver_en <= 1'b0;
      if (speaker_ocp) begin
        speaker_positive_output_en <= 1'b0;
        speaker_negative_output_en <= 1'b0;
      end
      if (hp_stage[`CRI_HPL_BIT]) begin
        left_headphone_driver_en <= 1'b1;
        hp_stage[`CRI_HPL_BIT] <= 1'b0;
      end
      if (hp_stage[`CRI_HPR_BIT]) begin
        right_headphone_driver_en <= 1'b1;
        hp_stage[`CRI_HPR_BIT] <= 1'b0;
      end
      if (spk_stage[`CRI_SPK_BIT]) begin
        speaker_positive_output_en <= 1'b1;
        speaker_negative_output_en <= 1'b1;
        spk_stage[`CRI_SPK_BIT] <= 1'b0;
      end
      if (do_write) begin
        if (!page && wptr == `CRI_PWR_CTRL_REG) begin
          pwr_ctrl <= wr_data;
        end else if (page && wptr == `CRI_HP_STAGE_REG) begin
          hp_stage <= wr_data;
        end else if (page && wptr == `CRI_SPK_STAGE_REG) begin
          spk_stage <= wr_data;
        end
      end
    end
  end
endmodule // cri_control_reset_init

/* sim/cri_i2c_host.sv */
// bus controller model: drives scl, pulls sda low through an open drain
`timescale 1ns/1ps
module cri_i2c_host (
  // clock
  input wire sys_clk,
  // bus
  input wire sda_oe,
  output reg scl,
  output wire sda
);
  reg drv;
  // pull-up: a released line reads high, never a stale level
  assign sda = !(drv || sda_oe);
  initial {scl, drv} = 2'b10;
  task step(input s, input d);
    begin
      repeat (6) @(posedge sys_clk);
      scl <= s;
      drv <= d;
    end
  endtask
  // sda moves a step after scl falls so no false start is seen
  task pulse(input a, input b);
    begin
      step(1'b0, drv);
      step(1'b0, a);
      step(1'b1, a);
      step(1'b1, b);
    end
  endtask
  // m pulls the ninth bit low; sampled halfway through the high phase
  task xfer(input [7:0] w, input m, output [7:0] r, output a);
    integer i;
    reg [8:0] v;
    reg [8:0] q;
    begin
      v = {w, !m};
      for (i = 8; i >= 0; i = i - 1) begin
        pulse(!v[i], !v[i]);
        q = {q[7:0], sda};
      end
      r = q[8:1];
      a = !q[0];
    end
  endtask
endmodule // cri_i2c_host

/* sim/cri_control_reset_init_properties.sv */
// port assertions for the control, reset and start-up block
`timescale 1ns/1ps
module cri_control_reset_init_properties #(
  parameter INIT_CYCLES = 20,
  parameter PLL_CYCLES = 50
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  input wire reset_n_pin,
  // bus
  input wire scl_in,
  input wire sda_out,
  input wire sda_oe,
  // state
  input wire [7:0] block_power,
  input wire init_busy,
  input wire pll_clocks_ready,
  input wire speaker_positive_output_en,
  input wire speaker_negative_output_en
);
  integer ic;
  integer pc;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // run lengths; a held pin restarts the init count
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ic <= 0;
      pc <= 0;
    end else begin
      ic <= (init_busy && reset_n_pin) ? ic + 1 : 0;
      pc <= block_power[0] ? pc + 1 : 0;
    end
  end
  sequence pin_low_s;
    !reset_n_pin [*3];
  endsequence
  sda_low_a: assert property (!sda_out)
    else $error("sda driven high");
  sda_edge_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda moved with scl high");
  rst_state_a: assert property ($fell(rst) |->
    block_power == 8'h00 && init_busy) else $error("bad reset state");
  pin_reset_a: assert property (pin_low_s |-> ##2
    block_power == 8'h00) else $error("pin reset ignored");
  init_long_a: assert property (ic <= INIT_CYCLES + 4)
    else $error("init too long");
  init_short_a: assert property ($fell(init_busy) |->
    ic >= INIT_CYCLES - 2) else $error("init too short");
  pll_early_a: assert property ($rose(pll_clocks_ready) |->
    pc >= PLL_CYCLES - 2) else $error("pll clocks early");
  pll_late_a: assert property (pc == PLL_CYCLES + 4 |->
    pll_clocks_ready) else $error("pll clocks late");
  spk_pair_a: assert property (speaker_positive_output_en ==
    speaker_negative_output_en) else $error("speaker halves differ");
endmodule // cri_control_reset_init_properties
bind cri_control_reset_init cri_control_reset_init_properties #(
  .INIT_CYCLES(INIT_CYCLES), .PLL_CYCLES(PLL_CYCLES)) chk_i (.sys_clk,
  .rst, .reset_n_pin, .scl_in, .sda_out, .sda_oe, .block_power,
  .init_busy, .pll_clocks_ready, .speaker_positive_output_en,
  .speaker_negative_output_en);

/* sim/cri_control_reset_init_tb_top.sv */
// self-checking bench for the control, reset and start-up block
`timescale 1ns/1ps
module cri_control_reset_init_tb_top;
  reg sys_clk = 1'b0;
  reg rst = 1'b1;
  reg pin = 1'b1;
  reg [2:0] ocp = 3'h0;
  reg [31:0] seed = 32'h0000E313;
  reg [7:0] d, r0, r1;
  reg k;
  integer fail_count = 0, comparisons = 0, n;
  wire scl, sda, sda_oe, busy, pll;
  wire [7:0] pwr;
  wire [3:0] en;
  initial forever #2.5 sys_clk = !sys_clk;
  cri_i2c_host h (.sys_clk, .sda_oe, .scl, .sda);
  cri_control_reset_init #(.INIT_CYCLES(20), .PLL_CYCLES(50)) dut (
    .sys_clk, .rst, .reset_n_pin(pin), .scl_in(scl), .sda_in(sda),
    .sda_out(), .sda_oe, .left_headphone_driver_ocp(ocp[2]),
    .right_headphone_driver_ocp(ocp[1]), .speaker_ocp(ocp[0]),
    .block_power(pwr), .init_busy(busy), .pll_clocks_ready(pll),
    .left_headphone_driver_en(en[3]), .right_headphone_driver_en(en[2]),
    .speaker_positive_output_en(en[1]), .speaker_negative_output_en(en[0]));
  function [7:0] xs(input x);
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      xs = seed[7:0];
    end
  endfunction
  task chk(input [79:0] nm, input [7:0] e, input [7:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task finish_test;
    begin
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task wait_init;
    begin
      n = 0;
      while (busy !== 1'b0 && n < 100) begin
        @(posedge sys_clk);
        n = n + 1;
      end
      chk("init", 8'h00, {7'h00, busy});
    end
  endtask
  task wr(input [7:0] a, input [23:0] v, input integer c);
    integer i;
    begin
      h.pulse(1'b0, 1'b1);
      h.xfer(8'h30, 1'b0, r0, k);
      chk("ack", 8'h01, {7'h00, k});
      h.xfer(a, 1'b0, r0, k);
      for (i = c - 1; i >= 0; i = i - 1) h.xfer(v[8 * i +: 8], 1'b0, r0, k);
      h.pulse(1'b1, 1'b0);
    end
  endtask
  task rd(input [7:0] a);
    begin
      h.pulse(1'b0, 1'b1);
      h.xfer(8'h30, 1'b0, r0, k);
      h.xfer(a, 1'b0, r0, k);
      h.pulse(1'b0, 1'b1);
      h.xfer(8'h31, 1'b0, r0, k);
      h.xfer(8'hFF, 1'b1, r0, k);
      h.xfer(8'hFF, 1'b0, r1, k);
      h.pulse(1'b1, 1'b0);
    end
  endtask
  initial begin
    repeat (40000) @(posedge sys_clk);
    fail_count = fail_count + 1;
    finish_test;
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    wait_init;
    chk("power", 8'h00, pwr);
    chk("stages", 8'h0F, {4'h0, en});
    repeat (3) begin
      d = xs(1'b0) & 8'hFE;
      if (d == 8'h30) d = 8'h32;
      h.pulse(1'b0, 1'b1);
      h.xfer(d, 1'b0, r0, k);
      h.pulse(1'b1, 1'b0);
      chk("nack", 8'h00, {7'h00, k});
    end
    d = xs(1'b0) & 8'hFE;
    wr(8'h00, {16'h0000, d}, 3);
    chk("power", d, pwr);
    rd(8'h02);
    chk("readback", d, r0);
    chk("status", 8'h00, r1);
    wr(8'h02, 24'h000001, 1);
    chk("pllhold", 8'h00, {7'h00, pll});
    n = 0;
    while (pll !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n = n + 1;
    end
    chk("pll", 8'h01, {7'h00, pll});
    rd(8'h02);
    chk("pllpwr", 8'h01, r0);
    chk("pllstat", 8'h02, r1);
    ocp <= 3'h7;
    @(posedge sys_clk);
    ocp <= 3'h0;
    repeat (4) @(posedge sys_clk);
    chk("tripped", 8'h00, {4'h0, en});
    wr(8'h00, 24'h000001, 1);
    wr(8'h1F, 24'h000080, 1);
    chk("left", 8'h08, {4'h0, en});
    wr(8'h1F, 24'h000040, 1);
    chk("right", 8'h0C, {4'h0, en});
    wr(8'h20, 24'h000080, 1);
    chk("speaker", 8'h0F, {4'h0, en});
    rd(8'h1F);
    chk("selfclear", 8'h00, r0 | r1);
    chk("kept", 8'h01, pwr);
    pin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("pinrst", 8'h00, pwr);
    wait_init;
    wr(8'h02, {16'h0000, d}, 1);
    wr(8'h01, 24'h000001, 1);
    chk("softrst", 8'h00, pwr);
    wait_init;
    rd(8'h01);
    chk("rstbit", 8'h00, r0 | r1);
    finish_test;
  end
endmodule // cri_control_reset_init_tb_top
